// [design/ioac_core.sv]
// Command core: get_input and accumulator_a on decoded 9-byte frames.
// Assumes frames arrive whole; host link framing lives outside.
`timescale 1ns/1ns
`default_nettype none
module ioac_core
  import ioac_pkg::*;
#(
  parameter logic [7:0] HOST_ADDR = 8'h02,
  parameter logic [7:0] MODULE_ADDR = 8'h01
) (
  input wire logic clk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic cmdValid, // command frame present
  output logic cmdReady, // command accepted
  input wire ioac_cmd_t cmd, // command frame
  input wire logic standalone, // 1: from stored program
  output logic replyValid, // direct-mode reply present
  input wire logic replyReady, // reply taken
  output ioac_reply_t reply, // reply frame
  output logic doneStrobe, // one pulse per finished command
  input wire logic [7:0] generalInput, // raw general inputs 0..7
  input wire logic [7:0] generalOutput, // driven output states
  input wire ioac_analog_t analog, // converted analog values
  output logic [31:0] accumulator // accumulator to sequencer
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_REPLY = 2'b11
  } ioac_state_t;

  ioac_state_t state, next_state;
  ioac_cmd_t held, next_held;
  ioac_reply_t next_reply;
  logic [31:0] next_accumulator;
  logic next_replyValid, next_doneStrobe, heldStandalone;
  logic next_heldStandalone;
  logic [7:0] inputs;

  ioac_sync #(.WIDTH(8)) u_sync (
    .clk(clk),
    .reset(reset),
    .din(generalInput),
    .dout(inputs)
  );

  // Read one port; valid flag low for an unknown bank or port
  function automatic logic [32:0] read_port(input logic [7:0] bank,
                                            input logic [7:0] port,
                                            input logic [7:0] din,
                                            input logic [7:0] dout,
                                            input ioac_analog_t an);
    logic [32:0] r;
    r = '0;
    unique case (bank)
      BANK_DIGITAL:
        if (port == PORT_ALL)
          r = {1'b1, 24'h000000, din};
        else if (port < 8'h08)
          r = {1'b1, 31'h0, din[port[2:0]]};
      BANK_ANALOG:
        unique case (port)
          PORT_AIN_A: r = {1'b1, 20'h0, an.ainA};
          PORT_AIN_B: r = {1'b1, 20'h0, an.ainB};
          PORT_SUPPLY_V: r = {1'b1, 16'h0, an.supplyV};
          PORT_TEMP: r = {1'b1, {16{an.temp[15]}}, an.temp};
          PORT_SUPPLY_I: r = {1'b1, 16'h0, an.supplyI};
          default: r = '0;
        endcase
      BANK_OUTPUTS:
        if (port < 8'h08)
          r = {1'b1, 31'h0, dout[port[2:0]]};
      default: r = '0;
    endcase
    return r;
  endfunction : read_port

  logic [32:0] portRead;
  logic signed [31:0] accS, opS;
  logic [63:0] product;
  logic csumOk;

  assign cmdReady = (state == ST_IDLE);
  assign accS = accumulator;
  assign opS = held.value;
  assign product = 64'(accS * opS);
  assign portRead = read_port(held.bank, held.cmdType, inputs,
                              generalOutput, analog);
  assign csumOk = ioac_sum8({held.addr, held.opcode, held.cmdType,
                             held.bank, held.value}) == held.checksum;

  always_comb
  begin
    next_state = state;
    next_held = held;
    next_heldStandalone = heldStandalone;
    next_accumulator = accumulator;
    next_reply = reply;
    next_replyValid = replyValid;
    next_doneStrobe = 1'b0;
    unique case (state)
      ST_IDLE:
        if (cmdValid)
        begin
          next_held = cmd;
          next_heldStandalone = standalone;
          next_state = ST_EXEC;
        end
      ST_EXEC:
      begin
        next_reply.hostAddr = HOST_ADDR;
        next_reply.targetAddr = MODULE_ADDR;
        next_reply.opcode = held.opcode;
        next_reply.value = 32'h0;
        next_reply.status = STATUS_OK;
        if (!heldStandalone && !csumOk)
          next_reply.status = STATUS_BAD_CSUM;
        else if (held.opcode == OPC_GET_INPUT)
        begin
          if (!portRead[32])
            next_reply.status = STATUS_BAD_TYPE;
          else
          begin
            next_reply.value = portRead[31:0];
            if (heldStandalone)
            begin
              if (held.bank == BANK_DIGITAL && held.cmdType == PORT_ALL)
                next_accumulator = {accumulator[31:8], inputs};
              else
                next_accumulator = portRead[31:0];
            end
          end
        end
        else if (held.opcode == OPC_ACCUM)
        begin
          next_reply.value = held.value;
          unique case (held.cmdType)
            8'(OP_ADD): next_accumulator = accumulator + held.value;
            8'(OP_SUB): next_accumulator = accumulator - held.value;
            8'(OP_MUL): next_accumulator = product[31:0];
            8'(OP_DIV), 8'(OP_MOD):
              // Divide by zero leaves accumulator as is, flags bad value
              if (held.value == 32'h0)
                next_reply.status = STATUS_BAD_VALUE;
              else if (held.cmdType == 8'(OP_DIV))
                next_accumulator = 32'(accS / opS);
              else
                next_accumulator = 32'(accS % opS);
            8'(OP_AND): next_accumulator = accumulator & held.value;
            8'(OP_OR): next_accumulator = accumulator | held.value;
            8'(OP_XOR): next_accumulator = accumulator ^ held.value;
            8'(OP_NOT): next_accumulator = ~accumulator;
            8'(OP_LOAD): next_accumulator = held.value;
            default: next_reply.status = STATUS_BAD_TYPE;
          endcase
        end
        else
          next_reply.status = STATUS_BAD_CMD;
        next_reply.checksum = ioac_sum8({next_reply.hostAddr,
          next_reply.targetAddr, next_reply.status, next_reply.opcode,
          next_reply.value});
        next_doneStrobe = 1'b1;
        // Stored-program commands get no reply frame
        if (heldStandalone)
          next_state = ST_IDLE;
        else
        begin
          next_replyValid = 1'b1;
          next_state = ST_REPLY;
        end
      end
      ST_REPLY:
        if (replyReady)
        begin
          next_replyValid = 1'b0;
          next_state = ST_IDLE;
        end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      held <= '0;
      heldStandalone <= 1'b0;
      accumulator <= ACCUM_RESET;
      reply <= '0;
      replyValid <= 1'b0;
      doneStrobe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      held <= next_held;
      heldStandalone <= next_heldStandalone;
      accumulator <= next_accumulator;
      reply <= next_reply;
      replyValid <= next_replyValid;
      doneStrobe <= next_doneStrobe;
    end
  end
endmodule : ioac_core
`default_nettype wire

// [design/ioac_pkg.sv]
// Package for the input-read and accumulator command slice.
// Assumes one clock domain; frames are 9 bytes, host link outside.
package ioac_pkg;
  localparam logic [7:0] OPC_GET_INPUT = 8'h0f;
  localparam logic [7:0] OPC_ACCUM = 8'h13;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  localparam logic [7:0] BANK_DIGITAL = 8'h00;
  localparam logic [7:0] BANK_ANALOG = 8'h01;
  localparam logic [7:0] BANK_OUTPUTS = 8'h02;
  localparam logic [7:0] PORT_ALL = 8'hff;
  localparam logic [7:0] PORT_AIN_A = 8'h00;
  localparam logic [7:0] PORT_AIN_B = 8'h04;
  localparam logic [7:0] PORT_SUPPLY_V = 8'h08;
  localparam logic [7:0] PORT_TEMP = 8'h09;
  localparam logic [7:0] PORT_SUPPLY_I = 8'h0a;
  localparam logic [31:0] ACCUM_RESET = 32'h0000_0000;
  localparam int FRAME_BYTES = 9;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MUL = 4'h2, OP_DIV = 4'h3,
    OP_MOD = 4'h4, OP_AND = 4'h5, OP_OR = 4'h6, OP_XOR = 4'h7,
    OP_NOT = 4'h8, OP_LOAD = 4'h9
  } ioac_op_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] opcode;
    logic [7:0] cmdType;
    logic [7:0] bank;
    logic [31:0] value;
    logic [7:0] checksum;
  } ioac_cmd_t;

  typedef struct packed {
    logic [7:0] hostAddr;
    logic [7:0] targetAddr;
    logic [7:0] status;
    logic [7:0] opcode;
    logic [31:0] value;
    logic [7:0] checksum;
  } ioac_reply_t;

  typedef struct packed {
    logic [11:0] ainA;
    logic [11:0] ainB;
    logic [15:0] supplyV;
    logic [15:0] temp;
    logic [15:0] supplyI;
  } ioac_analog_t;

  function automatic logic [7:0] ioac_sum8(input logic [63:0] bytes);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      s = s + bytes[8*i +: 8];
    end
    return s;
  endfunction : ioac_sum8
endpackage : ioac_pkg

// [design/ioac_sync.sv]
// Three-stage input synchroniser bank with agreement filter.
// Assumes inputs asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module ioac_sync
  import ioac_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic [WIDTH-1:0] din, // raw pins
  output logic [WIDTH-1:0] dout // filtered level
);
  logic [WIDTH-1:0] s1, s2, s3;
  logic [WIDTH-1:0] next_dout;

  always_comb
  begin
    // Change accepted only once stages two and three agree
    next_dout = dout;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2[i] == s3[i])
        next_dout[i] = s3[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : ioac_sync
`default_nettype wire

// [testbench/ioac_checker.sv]
// Checker for the command core: latency, hold and result relations.
// Assumes it is bound into ioac_core; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module ioac_checker
  import ioac_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire logic cmdValid, // request
  input wire logic cmdReady, // accept
  input wire ioac_cmd_t cmd, // frame
  input wire logic standalone, // mode
  input wire logic replyValid, // reply up
  input wire logic replyReady, // reply taken
  input wire ioac_reply_t reply, // reply
  input wire logic doneStrobe, // done
  input wire logic [31:0] accumulator // accumulator
);
  logic take;
  logic [7:0] sum;
  assign take = cmdValid && cmdReady;
  always_comb
  begin
    sum = 8'h00;
    for (int i = 1; i < 9; i++)
    begin
      sum = sum + reply[8*i +: 8];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reply_latency: assert property (
    take && !standalone |-> ##2 replyValid)
    else $error("reply late");
  a_done_latency: assert property (
    take && standalone |-> ##2 doneStrobe)
    else $error("done late");
  a_done_pulse: assert property (doneStrobe |=> !doneStrobe)
    else $error("done too long");
  a_reply_hold: assert property (
    replyValid && !replyReady |=> replyValid && $stable(reply))
    else $error("reply dropped");
  a_direct_keep: assert property (
    take && !standalone && cmd.opcode == OPC_GET_INPUT
    |=> $stable(accumulator) [*2])
    else $error("accumulator moved");
  a_reply_echo: assert property (
    take && !standalone |-> ##2 reply.opcode == $past(cmd.opcode, 2))
    else $error("opcode not echoed");
  a_reply_sum: assert property (
    replyValid |-> reply.checksum == sum)
    else $error("reply checksum");
  a_load_acc: assert property (
    take && standalone && cmd.opcode == OPC_ACCUM && cmd.cmdType == 8'h09
    |-> ##2 accumulator == $past(cmd.value, 2))
    else $error("load wrong");
endmodule : ioac_checker
bind ioac_core ioac_checker chk (
  .clk(clk),
  .reset(reset),
  .cmdValid(cmdValid),
  .cmdReady(cmdReady),
  .cmd(cmd),
  .standalone(standalone),
  .replyValid(replyValid),
  .replyReady(replyReady),
  .reply(reply),
  .doneStrobe(doneStrobe),
  .accumulator(accumulator)
);
`default_nettype wire

// [testbench/ioac_core_bench.sv]
// Self-checking bench: direct and standalone command sequences.
// Assumes the host model drives frames; expectations are hand-worked.
`timescale 1ns/1ns
`default_nettype none
module ioac_core_bench
  import ioac_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmdValid, cmdReady, standalone, replyValid, replyReady, doneStrobe;
  ioac_cmd_t cmd;
  ioac_reply_t reply, r;
  logic [7:0] generalInput = 8'ha5;
  logic [7:0] generalOutput = 8'h3c;
  ioac_analog_t analog = {12'h12e, 12'hfff, 16'h00f0, 16'hfffb, 16'h05dc};
  logic [31:0] accumulator;
  logic [31:0] opnd [10] = '{32'h64, 32'h5, 32'hc8, 32'hfffffffd,
    32'hfffffffc, 32'ha, 32'hff, 32'h100, 32'h3, 32'h0};
  logic [31:0] res [10] = '{32'h64, 32'h69, 32'hffffffa1, 32'h11d,
    32'hffffffb9, 32'hffffffff, 32'hff, 32'h1ff, 32'h1fc, 32'hfffffe03};
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] minus5k = 32'hffffec78;
  always #5 clk = ~clk;
  ioac_core uut (
    .clk(clk),
    .reset(reset),
    .cmdValid(cmdValid),
    .cmdReady(cmdReady),
    .cmd(cmd),
    .standalone(standalone),
    .replyValid(replyValid),
    .replyReady(replyReady),
    .reply(reply),
    .doneStrobe(doneStrobe),
    .generalInput(generalInput),
    .generalOutput(generalOutput),
    .analog(analog),
    .accumulator(accumulator)
  );
  ioac_host_model host (
    .clk(clk),
    .cmdValid(cmdValid),
    .cmdReady(cmdReady),
    .cmd(cmd),
    .standalone(standalone),
    .replyValid(replyValid),
    .replyReady(replyReady),
    .reply(reply),
    .doneStrobe(doneStrobe)
  );
  task automatic check(input string name, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask : check
  task automatic complete_run;
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic direct(input logic [7:0] op, ty, bk, input logic [31:0] v,
    input logic [7:0] st, input logic [31:0] exp);
    logic [7:0] sum;
    host.xfer(1'b0, op, ty, bk, v, st == STATUS_BAD_CSUM, r);
    // Receiver side checksum over the eight leading reply bytes
    sum = 8'h00;
    for (int i = 1; i < 9; i++)
      sum = sum + r[8*i +: 8];
    check("status", 32'(st), 32'(r.status));
    check("host", 32'h02, 32'(r.hostAddr));
    check("target", 32'h01, 32'(r.targetAddr));
    check("opcode", 32'(op), 32'(r.opcode));
    check("checksum", 32'(sum), 32'(r.checksum));
    if (st == STATUS_OK)
      check("value", exp, r.value);
  endtask : direct
  task automatic stand(input logic [7:0] op, ty, bk,
    input logic [31:0] v, exp);
    host.xfer(1'b1, op, ty, bk, v, 1'b0, r);
    check("accumulator", exp, accumulator);
  endtask : stand
  task automatic read_in(input logic [7:0] port, bk,
    input logic [31:0] exp);
    direct(OPC_GET_INPUT, port, bk, '0, STATUS_OK, exp);
  endtask : read_in
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    for (int p = 0; p < 8; p++)
    begin
      direct(OPC_GET_INPUT, p[7:0], BANK_DIGITAL, 32'hdeadbeef, STATUS_OK,
        {31'h0, generalInput[p]});
      direct(OPC_GET_INPUT, p[7:0], BANK_OUTPUTS, '0, STATUS_OK,
        {31'h0, generalOutput[p]});
    end
    read_in(PORT_AIN_A, BANK_ANALOG, 32'h12e);
    check("checksum", 32'ha5, 32'(r.checksum));
    read_in(PORT_AIN_B, BANK_ANALOG, 32'hfff);
    read_in(PORT_SUPPLY_V, BANK_ANALOG, 32'hf0);
    read_in(PORT_TEMP, BANK_ANALOG, 32'hfffffffb);
    read_in(PORT_SUPPLY_I, BANK_ANALOG, 32'h5dc);
    check("accumulator", 32'h0, accumulator);
    stand(OPC_GET_INPUT, PORT_AIN_A, BANK_ANALOG, '0, 32'h12e);
    for (int i = 0; i < 10; i++)
      stand(OPC_ACCUM, 8'((i+9)%10), 8'h5, opnd[i], res[i]);
    stand(OPC_GET_INPUT, PORT_ALL, BANK_DIGITAL, '0, 32'hfffffea5);
    direct(OPC_ACCUM, 8'h02, '0, minus5k, STATUS_OK, minus5k);
    check("checksum", 32'hdc, 32'(r.checksum));
    check("accumulator", 32'h001a7958, accumulator);
    direct(OPC_ACCUM, 8'h09, 8'h00, 32'h1, STATUS_BAD_CSUM, '0);
    direct(OPC_ACCUM, 8'h03, 8'h00, 32'h0, STATUS_BAD_VALUE, '0);
    direct(OPC_GET_INPUT, 8'h00, 8'h03, '0, STATUS_BAD_TYPE, '0);
    direct(8'h2a, 8'h00, 8'h00, '0, STATUS_BAD_CMD, '0);
    check("accumulator", 32'h001a7958, accumulator);
    // New pin level must pass the synchroniser before it is seen
    generalInput <= 8'h5a;
    repeat (6) @(posedge clk);
    read_in(PORT_ALL, BANK_DIGITAL, 32'h5a);
    complete_run();
  end
  initial
  begin
    #20000;
    num_errors++;
    complete_run();
  end
endmodule : ioac_core_bench
`default_nettype wire

// [testbench/ioac_host_model.sv]
// Host model: sends checksummed command frames, takes replies.
// Assumes the core's ready/valid handshake; moves only at rising edges.
`timescale 1ns/1ns
`default_nettype none
module ioac_host_model
  import ioac_pkg::*;
(
  input wire logic clk, // clock
  output logic cmdValid, // request
  input wire logic cmdReady, // accept
  output ioac_cmd_t cmd, // frame
  output logic standalone, // mode
  input wire logic replyValid, // reply up
  output logic replyReady, // reply taken
  input wire ioac_reply_t reply, // reply
  input wire logic doneStrobe // done
);
  initial
  begin
    cmdValid = 1'b0;
    cmd = '0;
    standalone = 1'b0;
    replyReady = 1'b0;
  end
  task automatic xfer(input logic sa, input logic [7:0] op, ty, bk,
    input logic [31:0] v, input logic bad, output ioac_reply_t r);
    ioac_cmd_t c;
    c = {8'h01, op, ty, bk, v, 8'h00};
    for (int i = 1; i < 9; i++)
    begin
      c.checksum = c.checksum + c[8*i +: 8];
    end
    c.checksum = c.checksum ^ {7'h00, bad};
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd <= c;
    standalone <= sa;
    @(negedge clk);
    while (!cmdReady) @(negedge clk);
    @(posedge clk);
    cmdValid <= 1'b0;
    // Released frame shows garbage, not the old bytes
    cmd <= ~c;
    @(negedge clk);
    while (!(sa ? doneStrobe : replyValid)) @(negedge clk);
    r = reply;
    if (!sa)
    begin
      // One stall cycle before taking the reply
      @(posedge clk);
      replyReady <= 1'b1;
      @(posedge clk);
      replyReady <= 1'b0;
    end
  endtask : xfer
endmodule : ioac_host_model
`default_nettype wire
